/* core/fifo_flag_params.svh */
`ifndef FIFO_FLAG_PARAMS_SVH
`define FIFO_FLAG_PARAMS_SVH

// array geometry
`define FQ_WORD_W 72
`define FQ_ADDR_W 14
`define FQ_CNT_W 15
`define FQ_DEPTH_STD 15'h4000
`define FQ_DEPTH_FT 15'h4001

// register byte offsets
`define FQ_REG_CTRL 8'h00
`define FQ_REG_AE_OFF 8'h04
`define FQ_REG_AF_OFF 8'h08
`define FQ_REG_STATUS 8'h0c

// control field positions
`define FQ_CTRL_FT_BIT 0
`define FQ_CTRL_ARD_BIT 1

// status field positions
`define FQ_ST_EMPTY_BIT 16
`define FQ_ST_FULL_BIT 17
`define FQ_ST_AE_BIT 18
`define FQ_ST_AF_BIT 19
`define FQ_ST_MARK_BIT 20
`define FQ_ST_SYNC_BIT 21

// reset values
`define FQ_CTRL_RST 2'h0
`define FQ_AE_OFF_RST 15'h007f
`define FQ_AF_OFF_RST 15'h007f

`endif

/* core/fifo_flag_pkg.sv */
package fifo_flag_pkg;
  typedef logic [71:0] word_t;
  typedef logic [13:0] ptr_t;
  typedef logic [14:0] cnt_t;
endpackage : fifo_flag_pkg

/* core/fifo_word_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module fifo_word_mem #(
  parameter int WIDTH = 72,
  parameter int AW = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  logic [WIDTH-1:0] rd_data_r;

  // array write port, no reset on the cells
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // read register doubles as the output register: holds until next load
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_r <= '0;
    end
    else if (rd_en_i)
    begin
      rd_data_r <= mem[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_r;
endmodule : fifo_word_mem
`default_nettype wire

/* core/almost_flag.sv */
`timescale 1ns/100ps
`default_nettype none
module almost_flag (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sync_mode_i,
  input wire logic hit_i,
  output logic flag_n_o
);
  logic flag_r;
  logic flag_nxt;

  // synchronous copy changes only at a clock edge
  always_comb
  begin
    flag_nxt = ~hit_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_r <= 1'b1;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  // asynchronous timing follows the level straight from the counters
  assign flag_n_o = sync_mode_i ? flag_r : ~hit_i;
endmodule : almost_flag
`default_nettype wire

/* core/fifo_flag_retransmit_echo.sv */
// Notes on behaviour
// - standard mode: retransmit setup ends when empty flag returns high
// - with mark set, writes stop at the marked location
// - almost-empty may move one cycle early during retransmit
// - synchronous timing: almost-full updates only on clock edges
// - timing select sampled during reset: high sync, low async
// - async timing: almost-full follows write and read immediately
// - async timing: almost-empty follows read and write immediately
// - sync almost-full deasserts one cycle after the freeing read
// - sync almost-empty deasserts one cycle after the filling write
// - threshold depth is array size, plus one in fall-through mode
// - standard mode: echo enable is select and enable combined, forced high when empty
// - echo enable is registered on the clock
// - output bus driven only while select and drive are both low
// - fall-through: echo low on loading cycles, high otherwise
// - first word falls into output register, output-ready goes low
// - read after last word raises output-ready and echo
// - asynchronous reads only in standard mode
// - first word loads without select or enable; later need both
`timescale 1ns/100ps
`default_nettype none
`include "fifo_flag_params.svh"
module fifo_flag_retransmit_echo (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flag_timing_select_i,
  input wire logic wr_en_n_i,
  input wire fifo_flag_pkg::word_t wr_data_i,
  input wire logic read_select_n_i,
  input wire logic rd_en_n_i,
  input wire logic output_drive_n_i,
  input wire logic retransmit_strobe_n_i,
  input wire logic mark_i,
  output fifo_flag_pkg::word_t output_bus_o,
  output logic output_bus_oe_o,
  output logic empty_flag_n_o,
  output logic full_flag_n_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o,
  output logic echo_read_enable_n_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import fifo_flag_pkg::*;

  ptr_t wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt, mark_ptr_r, mark_ptr_nxt;
  cnt_t mem_cnt_r, mem_cnt_nxt, marked_cnt_r, marked_cnt_nxt;
  logic out_valid_r, out_valid_nxt;
  logic mark_r, mark_nxt, mark_d_r, mark_d_nxt;
  logic rtx_busy_r, rtx_busy_nxt;
  logic ren_d_r, ren_d_nxt;
  logic empty_n_r, empty_n_nxt, full_n_r, full_n_nxt, echo_n_r, echo_n_nxt;
  logic sync_flags_r, sync_flags_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  cnt_t ae_off_r, ae_off_nxt, af_off_r, af_off_nxt;
  logic [31:0] wb_dat_r, wb_dat_nxt;
  logic ack_r, ack_nxt;
  logic ft_mode, async_rd, rd_req, wr_do, load, rtx_start, mark_full;
  cnt_t total, depth_max;
  logic ae_hit, af_hit;
  word_t rd_data;

  // async read is refused in fall-through mode
  assign ft_mode = ctrl_r[`FQ_CTRL_FT_BIT];
  assign async_rd = ctrl_r[`FQ_CTRL_ARD_BIT] & ~ft_mode;

  // read request: level in sync mode, falling enable edge in async mode
  assign rd_req = async_rd ? (ren_d_r & ~rd_en_n_i & ~read_select_n_i)
                           : (~rd_en_n_i & ~read_select_n_i);

  // stop writing once the region after the mark is full
  assign mark_full = mark_r & (marked_cnt_r == `FQ_DEPTH_STD);
  assign wr_do = ~wr_en_n_i & (mem_cnt_r != `FQ_DEPTH_STD) & ~mark_full & ~rtx_busy_r;

  // fall-through refills an empty output register without a read
  assign load = (mem_cnt_r != 15'h0000) & ~rtx_busy_r &
                (ft_mode ? (~out_valid_r | rd_req) : rd_req);
  assign rtx_start = ~retransmit_strobe_n_i & mark_r & ~rtx_busy_r;

  // output register counts as one more word in fall-through mode
  assign total = mem_cnt_r + cnt_t'(ft_mode & out_valid_r);
  assign depth_max = ft_mode ? `FQ_DEPTH_FT : `FQ_DEPTH_STD;
  assign af_hit = total >= (depth_max - af_off_r);
  assign ae_hit = total <= ae_off_r;

  // pointer, count, mark and retransmit next state
  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r + ptr_t'(wr_do);
    rd_ptr_nxt = rd_ptr_r + ptr_t'(load);
    mem_cnt_nxt = mem_cnt_r + cnt_t'(wr_do) - cnt_t'(load);
    out_valid_nxt = load ? 1'b1 : ((ft_mode & rd_req) ? 1'b0 : out_valid_r);
    mark_d_nxt = mark_i;
    mark_nxt = mark_i;
    mark_ptr_nxt = mark_ptr_r;
    marked_cnt_nxt = marked_cnt_r + cnt_t'(wr_do);
    if (mark_i & ~mark_d_r)
    begin
      // mark the word the next read would fetch
      mark_ptr_nxt = rd_ptr_r;
      marked_cnt_nxt = mem_cnt_r + cnt_t'(wr_do);
    end
    rtx_busy_nxt = rtx_start;
    if (rtx_start)
    begin
      // rewind reads; written words past the mark stay valid
      rd_ptr_nxt = mark_ptr_r;
      mem_cnt_nxt = marked_cnt_r + cnt_t'(wr_do);
      out_valid_nxt = 1'b0;
    end
    ren_d_nxt = rd_en_n_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      mem_cnt_r <= '0;
      out_valid_r <= 1'b0;
      mark_r <= 1'b0;
      mark_d_r <= 1'b0;
      mark_ptr_r <= '0;
      marked_cnt_r <= '0;
      rtx_busy_r <= 1'b0;
      ren_d_r <= 1'b1;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      mem_cnt_r <= mem_cnt_nxt;
      out_valid_r <= out_valid_nxt;
      mark_r <= mark_nxt;
      mark_d_r <= mark_d_nxt;
      mark_ptr_r <= mark_ptr_nxt;
      marked_cnt_r <= marked_cnt_nxt;
      rtx_busy_r <= rtx_busy_nxt;
      ren_d_r <= ren_d_nxt;
    end
  end

  // status flags lag the counters by one edge, echo is clocked
  always_comb
  begin
    if (ft_mode)
    begin
      empty_n_nxt = ~out_valid_r;
      echo_n_nxt = ~load;
    end
    else
    begin
      empty_n_nxt = (mem_cnt_r != 15'h0000) & ~rtx_busy_r;
      echo_n_nxt = (mem_cnt_r == 15'h0000) | read_select_n_i | rd_en_n_i;
    end
    full_n_nxt = (mem_cnt_r != `FQ_DEPTH_STD) & ~mark_full;
    // strap is watched only while reset is held
    sync_flags_nxt = rst_i ? flag_timing_select_i : sync_flags_r;
  end

  always_ff @(posedge clk_i)
  begin
    sync_flags_r <= sync_flags_nxt;
    if (rst_i)
    begin
      empty_n_r <= 1'b0;
      full_n_r <= 1'b1;
      echo_n_r <= 1'b1;
    end
    else
    begin
      empty_n_r <= empty_n_nxt;
      full_n_r <= full_n_nxt;
      echo_n_r <= echo_n_nxt;
    end
  end

  // almost-full: registered or immediate depending on the strap
  almost_flag u_af (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sync_mode_i(sync_flags_r),
    .hit_i(af_hit),
    .flag_n_o(almost_full_flag_n_o)
  );

  almost_flag u_ae (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sync_mode_i(sync_flags_r),
    .hit_i(ae_hit),
    .flag_n_o(almost_empty_flag_n_o)
  );

  fifo_word_mem #(
    .WIDTH(`FQ_WORD_W),
    .AW(`FQ_ADDR_W)
  ) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_do),
    .wr_addr_i(wr_ptr_r),
    .wr_data_i(wr_data_i),
    .rd_en_i(load),
    .rd_addr_i(rd_ptr_r),
    .rd_data_o(rd_data)
  );

  // bus goes high-z unless select and drive are both low
  assign output_bus_o = rd_data;
  assign output_bus_oe_o = ~read_select_n_i & ~output_drive_n_i;
  assign empty_flag_n_o = empty_n_r;
  assign full_flag_n_o = full_n_r;
  assign echo_read_enable_n_o = echo_n_r;

  // wishbone slave: one wait state, unmapped reads give zero
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    ae_off_nxt = ae_off_r;
    af_off_nxt = af_off_r;
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    wb_dat_nxt = 32'h0000_0000;
    if (ack_nxt & wb_we_i)
    begin
      unique case (wb_adr_i)
        `FQ_REG_CTRL: if (wb_sel_i[0]) ctrl_nxt = wb_dat_i[1:0];
        `FQ_REG_AE_OFF:
        begin
          if (wb_sel_i[0]) ae_off_nxt[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) ae_off_nxt[14:8] = wb_dat_i[14:8];
        end
        `FQ_REG_AF_OFF:
        begin
          if (wb_sel_i[0]) af_off_nxt[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) af_off_nxt[14:8] = wb_dat_i[14:8];
        end
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    unique case (wb_adr_i)
      `FQ_REG_CTRL: wb_dat_nxt[1:0] = ctrl_r;
      `FQ_REG_AE_OFF: wb_dat_nxt[14:0] = ae_off_r;
      `FQ_REG_AF_OFF: wb_dat_nxt[14:0] = af_off_r;
      `FQ_REG_STATUS:
      begin
        wb_dat_nxt[14:0] = total;
        wb_dat_nxt[`FQ_ST_EMPTY_BIT] = empty_n_r;
        wb_dat_nxt[`FQ_ST_FULL_BIT] = full_n_r;
        wb_dat_nxt[`FQ_ST_AE_BIT] = almost_empty_flag_n_o;
        wb_dat_nxt[`FQ_ST_AF_BIT] = almost_full_flag_n_o;
        wb_dat_nxt[`FQ_ST_MARK_BIT] = mark_r;
        wb_dat_nxt[`FQ_ST_SYNC_BIT] = sync_flags_r;
      end
      default: wb_dat_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `FQ_CTRL_RST;
      ae_off_r <= `FQ_AE_OFF_RST;
      af_off_r <= `FQ_AF_OFF_RST;
      ack_r <= 1'b0;
      wb_dat_r <= '0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ae_off_r <= ae_off_nxt;
      af_off_r <= af_off_nxt;
      ack_r <= ack_nxt;
      wb_dat_r <= wb_dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = wb_dat_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence rtx_seq;
    rtx_start ##1 rtx_busy_r;
  endsequence

  mark_write_stop_a: assert property (mark_full |-> !wr_do) else $error("write past mark");
  rtx_setup_a: assert property (rtx_seq and (!ft_mode) |=> !empty_flag_n_o ##1 !rtx_busy_r)
    else $error("retransmit setup wrong");
  af_sync_a: assert property (sync_flags_r && $past(sync_flags_r) && !$past(rst_i)
    |-> almost_full_flag_n_o == !$past(af_hit)) else $error("sync almost-full late");
  af_async_a: assert property (!sync_flags_r |-> almost_full_flag_n_o == !af_hit)
    else $error("async almost-full wrong");
  ae_async_a: assert property (!sync_flags_r |-> almost_empty_flag_n_o == !ae_hit)
    else $error("async almost-empty wrong");
  echo_empty_a: assert property (!ft_mode && mem_cnt_r == 15'h0000 |=> echo_read_enable_n_o)
    else $error("echo low while empty");
  ft_echo_a: assert property (ft_mode && load |=> !echo_read_enable_n_o)
    else $error("echo missed load");
  bus_drive_a: assert property (output_bus_oe_o == (!read_select_n_i && !output_drive_n_i))
    else $error("bus drive wrong");
  first_word_a: assert property (ft_mode && !out_valid_r && mem_cnt_r != 15'h0000 && !rtx_busy_r
    && retransmit_strobe_n_i |=> ##1 !empty_flag_n_o) else $error("first word stuck");
  depth_cap_a: assert property (total <= depth_max) else $error("count over depth");
endmodule : fifo_flag_retransmit_echo
`default_nettype wire

/* sim/fifo_reader_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fifo_reader_model (
  input wire logic clk_i,
  input wire logic want_i,
  output logic read_select_n_o,
  output logic rd_en_n_o
);
  // idle reader: both strobes high from time zero
  initial
  begin
    read_select_n_o = 1'h1;
    rd_en_n_o = 1'h1;
  end

  // select leads enable by one cycle so a held word is never skipped
  always @(posedge clk_i)
  begin
    read_select_n_o <= !want_i;
    rd_en_n_o <= !(want_i && !read_select_n_o);
  end
endmodule : fifo_reader_model
`default_nettype wire

/* sim/fifo_flag_retransmit_echo_test.sv */
`timescale 1ns/100ps
`default_nettype none
module fifo_flag_retransmit_echo_test;
  import fifo_flag_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, fts = 1'h1, wen_n = 1'h1, od_n = 1'h1, want = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, oe, emp_n, full_n, ae_n, af_n, echo_n, ack, rs_n, ren_n;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdt = 32'h0, rdo, rdt;
  word_t wdat = '0, bus;
  word_t expq[$];
  int miscompares = 0, num_checks = 0, seed = 58163;

  always #50 clk_i = ~clk_i;

  fifo_flag_retransmit_echo dut (
    .clk_i(clk_i), .rst_i(rst_i), .flag_timing_select_i(fts),
    .wr_en_n_i(wen_n), .wr_data_i(wdat), .read_select_n_i(rs_n),
    .rd_en_n_i(ren_n), .output_drive_n_i(od_n),
    .retransmit_strobe_n_i(1'h1),
    .mark_i(1'h0), .output_bus_o(bus), .output_bus_oe_o(oe),
    .empty_flag_n_o(emp_n), .full_flag_n_o(full_n), .almost_empty_flag_n_o(ae_n),
    .almost_full_flag_n_o(af_n), .echo_read_enable_n_o(echo_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdt), .wb_dat_o(rdo), .wb_ack_o(ack)
  );

  fifo_reader_model reader (.clk_i(clk_i), .want_i(want), .read_select_n_o(rs_n), .rd_en_n_o(ren_n));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  end
  endtask : chk

  task automatic chkw(input word_t e, input word_t g);
  begin
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD bus exp %h got %h", e, g);
    end
  end
  endtask : chkw

  // one classic cycle; read data taken only at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdt <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 50);
    if (n >= 50) miscompares++;
    rdt = rdo;
    cyc <= 1'h0; stb <= 1'h0;
    @(posedge clk_i);
  end
  endtask : wb

  task automatic push(input int k);
    word_t w;
  begin
    repeat (k)
    begin
      w = word_t'({$random(seed), $random(seed), $random(seed)});
      expq.push_back(w);
      wen_n <= 1'h0; wdat <= w;
      @(posedge clk_i);
    end
    wen_n <= 1'h1;
  end
  endtask : push

  task automatic conclude;
  begin
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask : conclude

  // output drive toggles at random to exercise the bus enable
  always @(posedge clk_i) od_n <= $random(seed);

  // every echo-low cycle must present the oldest word written
  always @(posedge clk_i)
  begin
    if (!rst_i)
    begin
      chk("oe", 32'(!rs_n && !od_n), 32'(oe));
      if (echo_n === 1'h0)
      begin
        if (expq.size() == 0)
          chk("echo", 32'h1, 32'h0);
        else
          chkw(expq.pop_front(), bus);
      end
    end
  end

  task automatic run(input logic sy, input logic ft);
    int n;
  begin
    rst_i <= 1'h1; fts <= sy;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk("rst", {27'h0, 2'h1, sy, 2'h3}, {27'h0, emp_n, full_n, ae_n, af_n, echo_n});
    wb(1'h1, 8'h04, 32'h4);
    wb(1'h1, 8'h08, 32'h4);
    wb(1'h1, 8'h00, {30'h0, ft, ft});
    wb(1'h0, 8'h04, 32'h0);
    chk("aeoff", 32'h4, rdt);
    wb(1'h0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rdt);
    wb(1'h0, 8'h0c, 32'h0);
    chk("sync", 32'(sy), 32'(rdt[21]));
    push(5);
    if (!ft)
    begin
      // count 5 over offset 4: async at once, sync one edge later
      @(posedge clk_i);
      chk("ae1", 32'(!sy), 32'(ae_n));
      @(posedge clk_i);
      chk("ae2", 32'h1, 32'(ae_n));
      push(16375);
      @(posedge clk_i);
      chk("af1", 32'(sy), 32'(af_n));
      @(posedge clk_i);
      chk("af2", 32'h0, 32'(af_n));
      push(4);
      repeat (2) @(posedge clk_i);
      chk("full", 32'h0, 32'(full_n));
      wen_n <= 1'h0;
      @(posedge clk_i);
      wen_n <= 1'h1;
    end
    else
    begin
      repeat (3) @(posedge clk_i);
      chk("ready", 32'h0, 32'(emp_n));
      chk("fall", 32'h4, expq.size());
    end
    want <= 1'h1;
    n = 0;
    while (expq.size() != 0 && n < 40000)
    begin
      @(posedge clk_i);
      n++;
    end
    repeat (4) @(posedge clk_i);
    want <= 1'h0;
    chk("drained", 32'h0, expq.size());
    chk("empty", 32'(ft), 32'(emp_n));
    chk("echo_hi", 32'h1, 32'(echo_n));
    chk("ae_low", 32'h0, 32'(ae_n));
    chk("af_hi", 32'h1, 32'(af_n));
    $display("test sync %0d fall %0d done", sy, ft);
  end
  endtask : run

  initial
  begin
    run(1'h1, 1'h0);
    run(1'h0, 1'h0);
    run(1'h1, 1'h1);
    conclude();
  end

  // whole run is about 70k cycles; allow nearly double
  initial
  begin
    #12000000;
    miscompares++;
    conclude();
  end
endmodule : fifo_flag_retransmit_echo_test
`default_nettype wire
